// [src/mifu_defs.svh]
// Overview of operation
// - Compare nibble for key group 1 at KEY_GROUP1_COMPARE, read/write, bits reset to 1.
// - Compare nibble for key group 0 at KEY_GROUP0_COMPARE, read/write, bits reset to 1.
// - Group 2 compare bits at CCH: pair bits 0-1, single bit 2, reset 1.
// - Input mask nibble at D0H: single, pair, group1, group0; reset 0.
// - Timer mask nibble at D1H: 1 Hz, 2 Hz, 16 Hz, 32 Hz; reset 0.
// - Dial done mask is bit 0 of D2H; upper bits unused, reset 0.
// - Unused bits have no storage and read as zero.
// - Input flags sit in bit 0 of C0H, C1H, C2H, C3H.
// - Timer flags at C4H matching mask bits; dial flag at C5H bit 0.
// - Pin select bits at C6H bits 0-1, C7H and C8H.
// - Flags set on their event regardless of the mask.
// - All addresses are reached directly with no paging.
// - Reading a flag nibble clears it; reset clears all flags.
// - Request when flag and mask are 1 and enable is 1; accept clears enable.
// - Vectors 102H to 10CH in rising priority, single pin highest.
`ifndef MIFU_DEFS_SVH
`define MIFU_DEFS_SVH
`define MIFU_A_FLAG_SINGLE 8'hC0
`define MIFU_A_FLAG_PAIR 8'hC1
`define MIFU_A_FLAG_KG1 8'hC2
`define MIFU_A_FLAG_KG0 8'hC3
`define MIFU_A_FLAG_TIMER 8'hC4
`define MIFU_A_FLAG_DIAL 8'hC5
`define MIFU_A_SEL_PAIR 8'hC6
`define MIFU_A_SEL_KG1 8'hC7
`define MIFU_A_SEL_KG0 8'hC8
`define MIFU_A_CMP_G2 8'hCC
`define MIFU_A_CMP_KG1 8'hCD
`define MIFU_A_CMP_KG0 8'hCE
`define MIFU_A_MASK_IN 8'hD0
`define MIFU_A_MASK_TMR 8'hD1
`define MIFU_A_MASK_DIAL 8'hD2
`define MIFU_CMP_RESET 4'hF
`define MIFU_MASK_RESET 4'h0
`define MIFU_CMP_G2_RESET 3'h7
`define MIFU_SEL_RESET 4'h0
`define MIFU_SEL_PAIR_RESET 2'h0
`define MIFU_VEC_TIMER 12'h102
`define MIFU_VEC_DIAL 12'h104
`define MIFU_VEC_KG0 12'h106
`define MIFU_VEC_KG1 12'h108
`define MIFU_VEC_PAIR 12'h10A
`define MIFU_VEC_SINGLE 12'h10C
`define MIFU_VECTOR_CYCLES 4'hC
`endif

// [src/mifu_pkg.sv]
`default_nettype none
package mifu_pkg;
   typedef enum logic [1:0]
   {
      MIFU_IDLE = 2'h1,
      MIFU_VECT = 2'h2
   } mifu_state_t;
endpackage
`default_nettype wire

// [src/mifu_top.sv]
// Local design decision: the address-and-strobe port.
`include "mifu_defs.svh"
`default_nettype none
module mifu_top
(
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RSTN,
   // Register port
   input wire logic [7:0] ADDR,
   input wire logic [3:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [3:0] RDATA,
   // Key input pins, asynchronous
   input wire logic [3:0] KEY_IN_G0,
   input wire logic [3:0] KEY_IN_G1,
   input wire logic [2:0] KEY_IN_G2,
   // Event pulses from on-chip blocks
   input wire logic [3:0] TIMER_EVT,
   input wire logic DIAL_DONE,
   // CPU sequencer side
   input wire logic IRQ_ENABLE_SET,
   input wire logic IRQ_ENABLE_CLR,
   output logic IRQ_ENABLED,
   output logic IRQ_REQ,
   output logic IRQ_TAKEN,
   output logic [11:0] IRQ_VECTOR
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [10:0] pin_meta_reg;
   logic [10:0] pin_sync_reg;
   always_ff @(posedge CLK_SYS or negedge RSTN)
      if (!RSTN)
      begin
         pin_meta_reg <= 11'h7FF;
         pin_sync_reg <= 11'h7FF;
      end
      else
      begin
         pin_meta_reg <= {KEY_IN_G2, KEY_IN_G1, KEY_IN_G0};
         pin_sync_reg <= pin_meta_reg;
      end

   // ****************************************
   // Control registers
   // ****************************************
   logic [3:0] compare_key_group0;
   logic [3:0] compare_key_group1;
   logic [2:0] compare_g2;
   logic [3:0] select_key_group0;
   logic [3:0] select_key_group1;
   logic [1:0] select_pair_pins_g2;
   logic [3:0] mask_in_reg;
   logic [3:0] mask_tmr_reg;
   logic mask_dial_done;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      hit = (a == b);
   endfunction

   always_ff @(posedge CLK_SYS or negedge RSTN)
      if (!RSTN)
      begin
         compare_key_group0 <= `MIFU_CMP_RESET;
         compare_key_group1 <= `MIFU_CMP_RESET;
         compare_g2 <= `MIFU_CMP_G2_RESET;
      end
      else if (WR)
      begin
         if (hit(ADDR, `MIFU_A_CMP_KG1))
            compare_key_group1 <= WDATA;
         if (hit(ADDR, `MIFU_A_CMP_KG0))
            compare_key_group0 <= WDATA;
         if (hit(ADDR, `MIFU_A_CMP_G2))
            compare_g2 <= WDATA[2:0];
      end

   always_ff @(posedge CLK_SYS or negedge RSTN)
      if (!RSTN)
      begin
         select_key_group0 <= `MIFU_SEL_RESET;
         select_key_group1 <= `MIFU_SEL_RESET;
         select_pair_pins_g2 <= `MIFU_SEL_PAIR_RESET;
      end
      else if (WR)
      begin
         if (hit(ADDR, `MIFU_A_SEL_PAIR))
            select_pair_pins_g2 <= WDATA[1:0];
         if (hit(ADDR, `MIFU_A_SEL_KG1))
            select_key_group1 <= WDATA;
         if (hit(ADDR, `MIFU_A_SEL_KG0))
            select_key_group0 <= WDATA;
      end

   // Masks take effect at once; writes under enable are the software's hazard
   always_ff @(posedge CLK_SYS or negedge RSTN)
      if (!RSTN)
      begin
         mask_in_reg <= `MIFU_MASK_RESET;
         mask_tmr_reg <= `MIFU_MASK_RESET;
         mask_dial_done <= 1'b0;
      end
      else if (WR)
      begin
         if (hit(ADDR, `MIFU_A_MASK_IN))
            mask_in_reg <= WDATA;
         if (hit(ADDR, `MIFU_A_MASK_TMR))
            mask_tmr_reg <= WDATA;
         if (hit(ADDR, `MIFU_A_MASK_DIAL))
            mask_dial_done <= WDATA[0];
      end

   // ****************************************
   // Factor flags
   // ****************************************
   // Order: single, pair, group1, group0
   logic [3:0] in_evt;
   logic [3:0] in_flag_reg;
   logic [3:0] tmr_flag_reg;
   logic dial_flag_reg;
   logic [3:0] in_rdclr;
   assign in_evt[3] = pin_sync_reg[10] != compare_g2[2];
   assign in_evt[2] = |(select_pair_pins_g2 & (pin_sync_reg[9:8] ^ compare_g2[1:0]));
   assign in_evt[1] = |(select_key_group1 & (pin_sync_reg[7:4] ^ compare_key_group1));
   assign in_evt[0] = |(select_key_group0 & (pin_sync_reg[3:0] ^ compare_key_group0));

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_in_flag
         assign in_rdclr[gi] = RD && hit(ADDR, `MIFU_A_FLAG_SINGLE + 8'(3 - gi));
         // Set beats read-clear so a coincident event is kept
         always_ff @(posedge CLK_SYS or negedge RSTN)
            if (!RSTN)
               in_flag_reg[gi] <= 1'b0;
            else if (in_evt[gi])
               in_flag_reg[gi] <= 1'b1;
            else if (in_rdclr[gi])
               in_flag_reg[gi] <= 1'b0;
      end
   endgenerate

   always_ff @(posedge CLK_SYS or negedge RSTN)
      if (!RSTN)
         tmr_flag_reg <= 4'h0;
      else if (RD && hit(ADDR, `MIFU_A_FLAG_TIMER))
         tmr_flag_reg <= TIMER_EVT;
      else
         tmr_flag_reg <= tmr_flag_reg | TIMER_EVT;

   always_ff @(posedge CLK_SYS or negedge RSTN)
      if (!RSTN)
         dial_flag_reg <= 1'b0;
      else if (DIAL_DONE)
         dial_flag_reg <= 1'b1;
      else if (RD && hit(ADDR, `MIFU_A_FLAG_DIAL))
         dial_flag_reg <= 1'b0;

   // ****************************************
   // Read port
   // ****************************************
   logic [3:0] rdata_next;
   always_comb
   begin
      rdata_next = 4'h0;
      case (ADDR)
         `MIFU_A_FLAG_SINGLE: rdata_next = {3'h0, in_flag_reg[3]};
         `MIFU_A_FLAG_PAIR: rdata_next = {3'h0, in_flag_reg[2]};
         `MIFU_A_FLAG_KG1: rdata_next = {3'h0, in_flag_reg[1]};
         `MIFU_A_FLAG_KG0: rdata_next = {3'h0, in_flag_reg[0]};
         `MIFU_A_FLAG_TIMER: rdata_next = tmr_flag_reg;
         `MIFU_A_FLAG_DIAL: rdata_next = {3'h0, dial_flag_reg};
         `MIFU_A_SEL_PAIR: rdata_next = {2'h0, select_pair_pins_g2};
         `MIFU_A_SEL_KG1: rdata_next = select_key_group1;
         `MIFU_A_SEL_KG0: rdata_next = select_key_group0;
         `MIFU_A_CMP_G2: rdata_next = {1'b0, compare_g2};
         `MIFU_A_CMP_KG1: rdata_next = compare_key_group1;
         `MIFU_A_CMP_KG0: rdata_next = compare_key_group0;
         `MIFU_A_MASK_IN: rdata_next = mask_in_reg;
         `MIFU_A_MASK_TMR: rdata_next = mask_tmr_reg;
         `MIFU_A_MASK_DIAL: rdata_next = {3'h0, mask_dial_done};
         default: rdata_next = 4'h0;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RSTN)
      if (!RSTN)
         RDATA <= 4'h0;
      else if (RD)
         RDATA <= rdata_next;
      else
         RDATA <= 4'h0;

   // ****************************************
   // Request and vectoring
   // ****************************************
   logic [3:0] in_pend;
   logic tmr_pend;
   logic dial_pend;
   logic any_pend;
   logic [11:0] vector_next;
   assign in_pend = in_flag_reg & mask_in_reg;
   assign tmr_pend = |(tmr_flag_reg & mask_tmr_reg);
   assign dial_pend = dial_flag_reg & mask_dial_done;
   assign any_pend = (|in_pend) | tmr_pend | dial_pend;

   always_comb
   begin
      // Highest priority first
      if (in_pend[3])
         vector_next = `MIFU_VEC_SINGLE;
      else if (in_pend[2])
         vector_next = `MIFU_VEC_PAIR;
      else if (in_pend[1])
         vector_next = `MIFU_VEC_KG1;
      else if (in_pend[0])
         vector_next = `MIFU_VEC_KG0;
      else if (dial_pend)
         vector_next = `MIFU_VEC_DIAL;
      else
         vector_next = `MIFU_VEC_TIMER;
   end

   mifu_pkg::mifu_state_t state_reg;
   logic [3:0] vcount_reg;

   always_ff @(posedge CLK_SYS or negedge RSTN)
      if (!RSTN)
      begin
         state_reg <= mifu_pkg::MIFU_IDLE;
         vcount_reg <= 4'h0;
         IRQ_ENABLED <= 1'b0;
         IRQ_REQ <= 1'b0;
         IRQ_TAKEN <= 1'b0;
         IRQ_VECTOR <= `MIFU_VEC_TIMER;
      end
      else
      begin
         IRQ_TAKEN <= 1'b0;
         case (state_reg)
            mifu_pkg::MIFU_IDLE:
            begin
               IRQ_REQ <= any_pend && IRQ_ENABLED;
               if (any_pend && IRQ_ENABLED)
               begin
                  IRQ_ENABLED <= 1'b0;
                  IRQ_VECTOR <= vector_next;
                  vcount_reg <= `MIFU_VECTOR_CYCLES - 4'h1;
                  state_reg <= mifu_pkg::MIFU_VECT;
               end
               else if (IRQ_ENABLE_SET)
                  IRQ_ENABLED <= 1'b1;
               else if (IRQ_ENABLE_CLR)
                  IRQ_ENABLED <= 1'b0;
            end
            mifu_pkg::MIFU_VECT:
            begin
               IRQ_REQ <= 1'b0;
               if (vcount_reg == 4'h1)
               begin
                  IRQ_TAKEN <= 1'b1;
                  state_reg <= mifu_pkg::MIFU_IDLE;
               end
               vcount_reg <= vcount_reg - 4'h1;
            end
            default:
               state_reg <= mifu_pkg::MIFU_IDLE;
         endcase
      end

   // ****************************************
   // Checks
   // ****************************************
   read_unused_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      RD && hit(ADDR, `MIFU_A_MASK_DIAL) |=> RDATA[3:1] == 3'h0)
      else $error("unused bits not zero");
   flag_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      RD && hit(ADDR, `MIFU_A_FLAG_DIAL) && !DIAL_DONE |=> !dial_flag_reg)
      else $error("dial flag not cleared by read");
   flag_set_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      DIAL_DONE |=> dial_flag_reg)
      else $error("dial flag not set");
   // Request pulse opens the sequence, taken pulse closes it 11 cycles on
   accept_ie_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      $rose(IRQ_REQ) |-> !IRQ_ENABLED ##11 IRQ_TAKEN)
      else $error("accept sequence wrong");
   req_cause_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      IRQ_REQ |-> $past(any_pend) && $past(IRQ_ENABLED))
      else $error("request without cause");
   single_prio_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      state_reg == mifu_pkg::MIFU_IDLE && IRQ_ENABLED && in_pend[3]
      |=> IRQ_VECTOR == `MIFU_VEC_SINGLE)
      else $error("priority vector wrong");
   mask_write_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      WR && hit(ADDR, `MIFU_A_MASK_TMR) ##1 RD && hit(ADDR, `MIFU_A_MASK_TMR)
      |=> RDATA == $past(WDATA, 2))
      else $error("timer mask readback wrong");
   edge_set_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      in_evt[0] |=> in_flag_reg[0])
      else $error("group0 flag not set");

endmodule
`default_nettype wire

// [tb/mifu_cpu_model.sv]
`default_nettype none
// ****************************************
// CPU sequencer stand-in
// ****************************************
module mifu_cpu_model
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // From the flag unit
   input wire logic irq_req,
   input wire logic irq_taken,
   input wire logic [11:0] vector,
   // Enable flag control
   output logic en_set,
   output logic en_clr
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] vec;
   int lat;
   int cnt;
   int n_req;
   initial
   begin
      en_set = 1'b0;
      en_clr = 1'b0;
   end
   // Masks are only written by the bench while the enable flag is clear
   task ei();
      @(posedge clk);
      en_set <= 1'b1;
      @(posedge clk);
      en_set <= 1'b0;
   endtask
   task di();
      @(posedge clk);
      en_clr <= 1'b1;
      @(posedge clk);
      en_clr <= 1'b0;
   endtask
   // Latency is counted from request to hand-back of the vector
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         n_req <= 0;
         cnt <= 0;
         lat <= 0;
         vec <= 12'h000;
      end
      else if (irq_req)
      begin
         vec <= vector;
         cnt <= 0;
         n_req <= n_req + 1;
      end
      else
      begin
         cnt <= cnt + 1;
         if (irq_taken)
            lat <= cnt + 1;
      end
   end
endmodule
`default_nettype wire

// [tb/test_maskable_interrupt_flag_unit.sv]
`include "mifu_defs.svh"
`default_nettype none
module test_maskable_interrupt_flag_unit;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK_SYS, RSTN, WR, RD, DIAL_DONE, es, ec;
   logic IRQ_ENABLED, IRQ_REQ, IRQ_TAKEN;
   logic [7:0] ADDR;
   logic [3:0] WDATA, RDATA, KG0, KG1, TIMER_EVT;
   logic [2:0] KG2;
   logic [11:0] IRQ_VECTOR;
   logic [3:0] d;
   logic [3:0] ds[9];
   logic [3:0] fx;
   int n_fail = 0;
   int checks_done = 0;
   // Read/write places: address, readable bits, reset value
   int ra[9] = '{8'hC6, 8'hC7, 8'hC8, 8'hCC, 8'hCD, 8'hCE, 8'hD0, 8'hD1, 8'hD2};
   int rm[9] = '{4'h3, 4'hF, 4'hF, 4'h7, 4'hF, 4'hF, 4'hF, 4'hF, 4'h1};
   int rs[9] = '{4'h0, 4'h0, 4'h0, 4'h7, 4'hF, 4'hF, 4'h0, 4'h0, 4'h0};
   int vq[$] = '{12'h106, 12'h104, 12'h102};
   int cq[$] = '{8'hC3, 8'hC5, 8'hC4};
   mifu_top i_dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .KEY_IN_G0(KG0), .KEY_IN_G1(KG1), .KEY_IN_G2(KG2),
      .TIMER_EVT(TIMER_EVT), .DIAL_DONE(DIAL_DONE), .IRQ_ENABLE_SET(es),
      .IRQ_ENABLE_CLR(ec), .IRQ_ENABLED(IRQ_ENABLED), .IRQ_REQ(IRQ_REQ),
      .IRQ_TAKEN(IRQ_TAKEN), .IRQ_VECTOR(IRQ_VECTOR));
   mifu_cpu_model i_cpu (.clk(CLK_SYS), .rstn(RSTN), .irq_req(IRQ_REQ),
      .irq_taken(IRQ_TAKEN), .vector(IRQ_VECTOR), .en_set(es), .en_clr(ec));
   initial
   begin
      CLK_SYS = 1'b0;
      forever #20 CLK_SYS = ~CLK_SYS;
   end
   task print_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [11:0] seen, input logic [11:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [3:0] v);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLK_SYS);
      WR <= 1'b0;
      @(posedge CLK_SYS);
   endtask
   // Write then read back with no gap between the strobes
   task wrc(input logic [7:0] a, input logic [3:0] v, input logic [3:0] e);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLK_SYS);
      WR <= 1'b0;
      RD <= 1'b1;
      @(posedge CLK_SYS);
      RD <= 1'b0;
      #1 chk(RDATA, e);
      @(posedge CLK_SYS);
   endtask
   task rc(input logic [7:0] a, input logic [3:0] e);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK_SYS);
      RD <= 1'b0;
      #1 chk(RDATA, e);
      @(posedge CLK_SYS);
   endtask
   // Pins are restored before reading, since a held mismatch keeps re-setting
   task pins(input logic [10:0] p, input logic [7:0] fa, input logic [3:0] e);
      {KG2, KG1, KG0} <= p;
      repeat (4) @(posedge CLK_SYS);
      {KG2, KG1, KG0} <= 11'h7FF;
      repeat (4) @(posedge CLK_SYS);
      rc(fa, e);
   endtask
   initial
   begin
      repeat (20000) @(posedge CLK_SYS);
      n_fail++;
      print_verdict();
   end
   initial
   begin
      {RSTN, WR, RD, DIAL_DONE, ADDR, WDATA, TIMER_EVT} = '0;
      {KG2, KG1, KG0} = 11'h7FF;
      void'($urandom(32'h94C1D035));
      repeat (20) @(posedge CLK_SYS);
      RSTN <= 1'b1;
      @(posedge CLK_SYS);
      for (int i = 0; i < 9; i++)
         rc(ra[i][7:0], rs[i][3:0]);
      for (int i = 0; i < 6; i++)
         rc(8'hC0 + i[7:0], 4'h0);
      $display("test reset values done");
      for (int i = 0; i < 9; i++)
      begin
         ds[i] = 4'($urandom);
         wrc(ra[i][7:0], ds[i], ds[i] & rm[i][3:0]);
      end
      wr(8'hC4, 4'hF);
      rc(8'hC4, 4'h0);
      rc(8'hCF, 4'h0);
      $display("test register access done");
      foreach (ra[i])
         wr(ra[i][7:0], rs[i][3:0]);
      // Random selects and compares leave mismatches that latch input flags
      fx = {~ds[3][2], |(ds[0][1:0] & ~ds[3][1:0]), |(ds[1] & ~ds[4]), |(ds[2] & ~ds[5])};
      for (int i = 0; i < 6; i++)
         rc(8'hC0 + i[7:0], i < 4 ? {3'h0, fx[3 - i]} : 4'h0);
      for (int i = 0; i < 4; i++)
      begin
         d = 4'($urandom % 15 + 1);
         TIMER_EVT <= d;
         @(posedge CLK_SYS);
         TIMER_EVT <= 4'h0;
         @(posedge CLK_SYS);
         rc(8'hC4, d);
         rc(8'hC4, 4'h0);
      end
      DIAL_DONE <= 1'b1;
      @(posedge CLK_SYS);
      DIAL_DONE <= 1'b0;
      rc(8'hC5, 4'h1);
      rc(8'hC5, 4'h0);
      $display("test event flags done");
      wr(8'hC8, 4'h4);
      wr(8'hC7, 4'h2);
      wr(8'hC6, 4'h1);
      pins(11'h7FB, 8'hC3, 4'h1);
      pins(11'h7FE, 8'hC3, 4'h0);
      pins(11'h7DF, 8'hC2, 4'h1);
      pins(11'h6FF, 8'hC1, 4'h1);
      pins(11'h3FF, 8'hC0, 4'h1);
      wr(8'hCE, 4'hB);
      pins(11'h7FF, 8'hC3, 4'h1);
      wr(8'hCE, 4'hF);
      rc(8'hC3, 4'h1);
      rc(8'hC3, 4'h0);
      $display("test key inputs done");
      i_cpu.di();
      rc(8'hC4, 4'h0);
      wr(8'hD0, 4'hF);
      wr(8'hD1, 4'hF);
      wr(8'hD2, 4'h1);
      TIMER_EVT <= 4'h1;
      DIAL_DONE <= 1'b1;
      @(posedge CLK_SYS);
      TIMER_EVT <= 4'h0;
      DIAL_DONE <= 1'b0;
      pins(11'h7FB, 8'hC2, 4'h0);
      chk(i_cpu.n_req, 0);
      foreach (vq[i])
      begin
         i_cpu.ei();
         repeat (20) @(posedge CLK_SYS);
         chk(i_cpu.vec, vq[i][11:0]);
         chk(i_cpu.lat, `MIFU_VECTOR_CYCLES - 4'h1);
         chk(IRQ_ENABLED, 1'b0);
         chk(i_cpu.n_req, i + 1);
         // Flags survive acceptance, so the handler clears its own
         rc(cq[i][7:0], 4'h1);
      end
      i_cpu.ei();
      repeat (20) @(posedge CLK_SYS);
      chk(i_cpu.n_req, 3);
      i_cpu.di();
      pins(11'h3FB, 8'hC1, 4'h0);
      i_cpu.ei();
      repeat (20) @(posedge CLK_SYS);
      chk(i_cpu.vec, 12'h10C);
      rc(8'hC0, 4'h1);
      i_cpu.ei();
      repeat (20) @(posedge CLK_SYS);
      chk(i_cpu.vec, 12'h106);
      chk(i_cpu.n_req, 5);
      rc(8'hC3, 4'h1);
      $display("test interrupt sequence done");
      print_verdict();
   end
endmodule
`default_nettype wire
